// File: hw/tccu_pkg.sv
// package of constants for the timer capture compare unit
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package tccu_pkg;

	localparam int unsigned W_TMR  = 16;
	localparam int unsigned W_BYTE = 8;
	localparam int unsigned W_ADDR = 4;

	// register offsets
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_SOURCE  = 4'h1;
	localparam logic [3:0] OFS_LOW     = 4'h2;
	localparam logic [3:0] OFS_HIGH    = 4'h3;
	localparam logic [3:0] OFS_IRQ     = 4'h4;
	localparam logic [3:0] OFS_OPTION  = 4'h5;

	// control register fields
	localparam int unsigned CTL_EN   = 7;
	localparam int unsigned CTL_MODE = 0;
	localparam int unsigned W_MODE   = 4;
	// option register fields
	localparam int unsigned OPT_TSEL = 0;
	localparam int unsigned OPT_ODRN = 1;
	localparam int unsigned W_SRC    = 2;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// mode encodings
	localparam logic [3:0] M_TGL_CLR   = 4'h1;
	localparam logic [3:0] M_TGL       = 4'h2;
	localparam logic [3:0] M_CAP_ANY   = 4'h3;
	localparam logic [3:0] M_CAP_FALL  = 4'h4;
	localparam logic [3:0] M_CAP_RISE  = 4'h5;
	localparam logic [3:0] M_CAP_R4    = 4'h6;
	localparam logic [3:0] M_CAP_R16   = 4'h7;
	localparam logic [3:0] M_SET       = 4'h8;
	localparam logic [3:0] M_CLR       = 4'h9;
	localparam logic [3:0] M_PULSE     = 4'ha;
	localparam logic [3:0] M_PULSE_CLR = 4'hb;

	// capture source encodings
	localparam logic [1:0] SRC_PIN  = 2'h0;
	localparam logic [1:0] SRC_AUX0 = 2'h1;
	localparam logic [1:0] SRC_AUX1 = 2'h2;
	localparam logic [1:0] SRC_AUX2 = 2'h3;

	localparam logic [3:0] PS_LAST4  = 4'h3;
	localparam logic [3:0] PS_LAST16 = 4'hf;
	localparam logic [3:0] PS_ZERO   = 4'h0;

endpackage : tccu_pkg

// File: hw/tccu_edge_if.sv
// interface between the main unit and its edge qualifier
`timescale 1ns/1ns
interface tccu_edge_if;
	logic       in_sync;
	logic [3:0] mode;
	logic       active;
	logic       event_hit;
	modport qual (input in_sync, input mode, input active, output event_hit);
	modport core (output in_sync, output mode, output active, input event_hit);
endinterface : tccu_edge_if

// File: hw/tccu_sync.sv
// three-stage synchronizer with agreement filter
`timescale 1ns/1ns
module tccu_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// async level in, clean level out
	input  wire logic din,
	output logic      dout
);
	import tccu_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} tccu_sync_t;

	tccu_sync_t st;
	tccu_sync_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// take the level only once two later stages agree
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.q;
endmodule // tccu_sync

// File: hw/tccu_edge_qual.sv
// edge detect and capture prescaler
`timescale 1ns/1ns
module tccu_edge_qual (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// link to core
	tccu_edge_if.qual e
);
	import tccu_pkg::*;

	typedef struct packed {
		logic       prev;
		logic [3:0] ps;
	} tccu_qual_t;

	tccu_qual_t st;
	tccu_qual_t next_st;
	logic       rise;
	logic       fall;

	always_comb begin
		next_st = st;
		rise = e.in_sync & ~st.prev;
		fall = ~e.in_sync & st.prev;
		e.event_hit = 1'b0;
		next_st.prev = e.in_sync;
		if (!e.active) begin
			next_st.ps = PS_ZERO;
		end else begin
			unique case (e.mode)
				M_CAP_FALL: e.event_hit = fall;
				M_CAP_RISE: e.event_hit = rise;
				M_CAP_ANY:  e.event_hit = rise | fall;
				M_CAP_R4: begin
					if (rise) begin
						// counter survives prescale changes
						next_st.ps = (st.ps >= PS_LAST4) ? PS_ZERO
							: st.ps + 4'h1;
						e.event_hit = (st.ps >= PS_LAST4);
					end
				end
				M_CAP_R16: begin
					if (rise) begin
						next_st.ps = st.ps + 4'h1;
						e.event_hit = (st.ps == PS_LAST16);
					end
				end
				default: e.event_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // tccu_edge_qual

// File: hw/tccu_top.sv
// capture compare channel top with register port
`timescale 1ns/1ns
module tccu_top (
	// clock and reset
	input  wire logic                        CLOCK,
	input  wire logic                        RST,
	// register port
	input  wire logic [tccu_pkg::W_ADDR-1:0] ADDR,
	input  wire logic [tccu_pkg::W_BYTE-1:0] WDATA,
	input  wire logic                        WR,
	input  wire logic                        RD,
	output logic      [tccu_pkg::W_BYTE-1:0] RDATA,
	// shared timers
	input  wire logic [tccu_pkg::W_TMR-1:0]  TIMER_A,
	input  wire logic [tccu_pkg::W_TMR-1:0]  TIMER_B,
	output logic                             TIMER_A_CLR,
	output logic                             TIMER_B_CLR,
	// capture sources
	input  wire logic                        PIN_IN,
	input  wire logic [2:0]                  AUX_SRC,
	// output pin
	output logic                             PIN_OUT,
	output logic                             PIN_OE,
	input  wire logic                        PIN_DIR_OUT,
	output logic                             CMP_OUT,
	// sleep and interrupt status
	input  wire logic                        SLEEP,
	input  wire logic                        TIMER_RUNS,
	output logic                             IRQ_FLAG,
	output logic                             WAKE
);
	import tccu_pkg::*;

	typedef struct packed {
		logic [7:0]  control;
		logic [7:0]  source;
		logic [1:0]  option;
		logic [15:0] value;
		logic        flag;
		logic        irq_en;
		logic        latch;
		logic [7:0]  rdata;
		logic        pulse;
		logic        match_prev;
	} tccu_state_t;

	tccu_state_t st;
	tccu_state_t next_st;

	tccu_edge_if eif ();

	logic        pin_sync;
	logic [2:0]  aux_sync;
	logic        src_level;
	logic [3:0]  mode;
	logic        enabled;
	logic        cap_mode;
	logic        cmp_mode;
	logic [15:0] timer_sel;
	logic        match;
	logic        match_edge;
	logic        wr_ctl;
	logic        do_clr;

	// ------------------------------------------------------------------
	// input synchronizers
	// ------------------------------------------------------------------
	tccu_sync u_sync_pin (
		.clk  (CLOCK),
		.rst  (RST),
		.din  (PIN_IN),
		.dout (pin_sync)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_aux
			tccu_sync u_sync_aux (
				.clk  (CLOCK),
				.rst  (RST),
				.din  (AUX_SRC[gi]),
				.dout (aux_sync[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// mode decode and source selection
	// ------------------------------------------------------------------
	assign mode    = st.control[CTL_MODE +: W_MODE];
	assign enabled = st.control[CTL_EN];
	assign cap_mode = (mode == M_CAP_ANY) || (mode == M_CAP_FALL) ||
		(mode == M_CAP_RISE) || (mode == M_CAP_R4) ||
		(mode == M_CAP_R16);
	assign cmp_mode = (mode == M_TGL_CLR) || (mode == M_TGL) ||
		(mode == M_SET) || (mode == M_CLR) ||
		(mode == M_PULSE) || (mode == M_PULSE_CLR);

	always_comb begin
		src_level = pin_sync;
		unique case (st.source[W_SRC-1:0])
			// pin level is read in either direction, so a port write
			// that drives the pin as an output still triggers a capture
			SRC_PIN:  src_level = pin_sync;
			SRC_AUX0: src_level = aux_sync[0];
			SRC_AUX1: src_level = aux_sync[1];
			SRC_AUX2: src_level = aux_sync[2];
		endcase
	end

	assign eif.in_sync = src_level;
	assign eif.mode    = mode;
	assign eif.active  = enabled & cap_mode;

	tccu_edge_qual u_qual (
		.clk (CLOCK),
		.rst (RST),
		.e   (eif)
	);

	// ------------------------------------------------------------------
	// timer selection and compare
	// ------------------------------------------------------------------
	// first timer by default, the selected timer is cleared on a match in the clearing modes
	assign timer_sel = st.option[OPT_TSEL] ? TIMER_B : TIMER_A;
	// held timer during sleep simply keeps its count, capture still works
	assign match = enabled & cmp_mode & (timer_sel == st.value);
	assign match_edge = match & ~st.match_prev;
	assign do_clr = match_edge &&
		((mode == M_TGL_CLR) || (mode == M_PULSE_CLR));

	assign wr_ctl = WR && (ADDR == OFS_CONTROL);

	// ------------------------------------------------------------------
	// state update
	// ------------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.match_prev = match;
		next_st.pulse = 1'b0;
		if (WR) begin
			unique case (ADDR)
				OFS_CONTROL: next_st.control = WDATA;
				OFS_SOURCE:  next_st.source  = WDATA;
				OFS_LOW:     next_st.value[7:0]  = WDATA;
				OFS_HIGH:    next_st.value[15:8] = WDATA;
				OFS_IRQ: begin
					next_st.flag   = WDATA[0];
					next_st.irq_en = WDATA[1];
				end
				OFS_OPTION:  next_st.option = WDATA[1:0];
				default: ;
			endcase
		end
		if (eif.event_hit) begin
			next_st.value = timer_sel;
			next_st.flag  = 1'b1;
		end
		if (match_edge) begin
			next_st.flag = 1'b1;
			unique case (mode)
				M_TGL_CLR, M_TGL: next_st.latch = ~st.latch;
				M_SET:            next_st.latch = 1'b1;
				M_CLR:            next_st.latch = 1'b0;
				M_PULSE, M_PULSE_CLR: next_st.pulse = 1'b1;
				default: ;
			endcase
		end
		// clearing control wins over a match in the same cycle
		if (wr_ctl && WDATA == RST_BYTE) begin
			next_st.latch = 1'b0;
			next_st.pulse = 1'b0;
		end
		if (RD) begin
			unique case (ADDR)
				OFS_CONTROL: next_st.rdata = st.control;
				OFS_SOURCE:  next_st.rdata = st.source;
				OFS_LOW:     next_st.rdata = st.value[7:0];
				OFS_HIGH:    next_st.rdata = st.value[15:8];
				OFS_IRQ:     next_st.rdata = {6'h00, st.irq_en, st.flag};
				OFS_OPTION:  next_st.rdata = {6'h00, st.option};
				default:     next_st.rdata = RST_BYTE;
			endcase
		end else begin
			next_st.rdata = RST_BYTE;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign RDATA       = st.rdata;
	assign TIMER_A_CLR = do_clr & ~st.option[OPT_TSEL];
	assign TIMER_B_CLR = do_clr & st.option[OPT_TSEL];
	assign CMP_OUT     = st.latch | st.pulse;
	// open drain only pulls low, push pull drives both levels
	assign PIN_OUT = st.option[OPT_ODRN] ? 1'b0 : CMP_OUT;
	assign PIN_OE  = PIN_DIR_OUT & (st.option[OPT_ODRN] ? ~CMP_OUT
		: 1'b1);
	assign IRQ_FLAG = st.flag;
	// compare matches whether or not the timer moves; sleep and a running timer gate the wake
	assign WAKE = SLEEP & TIMER_RUNS & st.flag & st.irq_en;
endmodule // tccu_top

// File: tb/tccu_timer_model.sv
// timer model that feeds the capture compare channel
`timescale 1ns/1ns
module tccu_timer_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// control
	input  wire logic        run,
	input  wire logic        clr,
	// count
	output logic      [15:0] cnt
);
	logic [1:0] pre;
	// synchronous count on every fourth clock, never on the raw clock
	always_ff @(posedge clk) begin
		if (rst || clr) begin
			cnt <= 16'h0000;
			pre <= 2'h0;
		end else if (run) begin
			pre <= pre + 2'h1;
			if (pre == 2'h3)
				cnt <= cnt + 16'h0001;
		end
	end
endmodule // tccu_timer_model

// File: tb/tccu_asserts.sv
// assertions on the capture compare channel ports
`timescale 1ns/1ns
module tccu_asserts (
	// clock and reset
	input wire logic                        CLOCK,
	input wire logic                        RST,
	// register port
	input wire logic [tccu_pkg::W_ADDR-1:0] ADDR,
	input wire logic [tccu_pkg::W_BYTE-1:0] WDATA,
	input wire logic                        WR,
	input wire logic                        RD,
	input wire logic [tccu_pkg::W_BYTE-1:0] RDATA,
	// timer clears and pin
	input wire logic                        TIMER_A_CLR,
	input wire logic                        TIMER_B_CLR,
	input wire logic                        PIN_OUT,
	input wire logic                        PIN_OE,
	input wire logic                        PIN_DIR_OUT,
	input wire logic                        CMP_OUT,
	// status
	input wire logic                        SLEEP,
	input wire logic                        TIMER_RUNS,
	input wire logic                        IRQ_FLAG,
	input wire logic                        WAKE
);
	import tccu_pkg::*;
	logic [7:0] ctl;
	logic [7:0] opt;
	logic       ien;
	wire  [3:0] md = ctl[3:0];
	wire        on = ctl[CTL_EN] && (md == M_TGL_CLR || md == M_TGL
		|| (md >= M_SET && md <= M_PULSE_CLR));
	// mirror of the software settings
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctl <= 8'h00;
			opt <= 8'h00;
			ien <= 1'b0;
		end else if (WR) begin
			if (ADDR == OFS_CONTROL)
				ctl <= WDATA;
			if (ADDR == OFS_OPTION)
				opt <= WDATA;
			if (ADDR == OFS_IRQ)
				ien <= WDATA[1];
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	chk_clr_a_mode: assert property (TIMER_A_CLR |-> ctl[CTL_EN]
		&& (md == M_TGL_CLR || md == M_PULSE_CLR) && !opt[OPT_TSEL])
		else $error("timer a cleared outside a clearing mode");
	chk_clr_b_sel: assert property (TIMER_B_CLR |-> opt[OPT_TSEL])
		else $error("timer b cleared while not selected");
	chk_match_flag: assert property ((TIMER_A_CLR || TIMER_B_CLR)
		&& !WR |=> IRQ_FLAG) else $error("match left flag clear");
	chk_flag_sticky: assert property (IRQ_FLAG
		&& !(WR && ADDR == OFS_IRQ) |=> IRQ_FLAG)
		else $error("flag dropped without software");
	chk_zero_ctl: assert property (WR && ADDR == OFS_CONTROL
		&& WDATA == 8'h00 |-> ##2 !CMP_OUT)
		else $error("latch high after control cleared");
	chk_pulse_one: assert property ($rose(CMP_OUT) && ctl[CTL_EN]
		&& (md == M_PULSE || md == M_PULSE_CLR) |=> !CMP_OUT)
		else $error("pulse longer than one cycle");
	chk_open_drain: assert property (opt[OPT_ODRN] && on
		&& PIN_DIR_OUT |-> !PIN_OUT && PIN_OE == !CMP_OUT)
		else $error("open drain drive wrong");
	chk_wake_rule: assert property (WAKE ==
		(SLEEP && TIMER_RUNS && IRQ_FLAG && ien))
		else $error("wake wrong");
	chk_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read cycle");
	chk_rd_unmap: assert property ($past(RD)
		&& $past(ADDR) > OFS_OPTION |-> RDATA == 8'h00)
		else $error("unmapped read not zero");
endmodule // tccu_asserts
bind tccu_top tccu_asserts chk_u (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.TIMER_A_CLR(TIMER_A_CLR), .TIMER_B_CLR(TIMER_B_CLR),
	.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_DIR_OUT(PIN_DIR_OUT),
	.CMP_OUT(CMP_OUT), .SLEEP(SLEEP), .TIMER_RUNS(TIMER_RUNS),
	.IRQ_FLAG(IRQ_FLAG), .WAKE(WAKE));

// File: tb/tccu_top_tb.sv
// self-checking bench of the capture compare channel
`timescale 1ns/1ns
module tccu_top_tb;
	import tccu_pkg::*;
	typedef struct packed {
		logic [3:0] mode;
		logic [1:0] src;
		logic [3:0] drv;
		logic [4:0] n;
		logic       exp;
	} tccu_row_t;
	logic        clk, rst, wr, rd, run, tclr, dir, sleep, truns;
	logic        ca, cb, po, poe, cmp, flag, wake, seen;
	logic [3:0]  addr, lines;
	logic [7:0]  wdata, rdata, d;
	logic [15:0] ta, tb2;
	int          num_errors, tests_run, i, k;
	tccu_row_t   rows [10] = '{
		'{M_CAP_FALL, SRC_PIN, 4'h1, 5'h01, 1'b1},
		'{M_CAP_RISE, SRC_PIN, 4'h1, 5'h01, 1'b1},
		'{M_CAP_ANY, SRC_PIN, 4'h1, 5'h01, 1'b1},
		'{M_CAP_R4, SRC_PIN, 4'h1, 5'h03, 1'b0},
		'{M_CAP_R4, SRC_PIN, 4'h1, 5'h01, 1'b0},
		'{M_CAP_R4, SRC_PIN, 4'h1, 5'h04, 1'b1},
		'{M_CAP_R16, SRC_PIN, 4'h1, 5'h0f, 1'b0},
		'{M_CAP_R16, SRC_PIN, 4'h1, 5'h10, 1'b1},
		'{M_CAP_RISE, SRC_AUX1, 4'h4, 5'h01, 1'b1},
		'{M_CAP_RISE, SRC_AUX0, 4'h4, 5'h01, 1'b0}};
	logic [3:0]  cm [6] = '{M_TGL_CLR, M_TGL, M_PULSE, M_PULSE_CLR,
		M_SET, M_CLR};

	tccu_top dut_u (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .TIMER_A(ta), .TIMER_B(tb2),
		.TIMER_A_CLR(ca), .TIMER_B_CLR(cb), .PIN_IN(lines[0]),
		.AUX_SRC(lines[3:1]), .PIN_OUT(po), .PIN_OE(poe),
		.PIN_DIR_OUT(dir), .CMP_OUT(cmp), .SLEEP(sleep),
		.TIMER_RUNS(truns), .IRQ_FLAG(flag), .WAKE(wake));
	tccu_timer_model tmr_a (.clk(clk), .rst(rst), .run(run),
		.clr(ca | tclr), .cnt(ta));
	tccu_timer_model tmr_b (.clk(clk), .rst(rst), .run(run),
		.clr(cb), .cnt(tb2));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	task automatic pulse(input logic [3:0] m, input int n);
		repeat (n) begin
			lines <= m;
			repeat (8) @(posedge clk);
			lines <= 4'h0;
			repeat (8) @(posedge clk);
		end
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report;
	end
	initial begin
		{rst, wr, rd, run, tclr, dir, sleep, truns} = 8'h80;
		{addr, wdata, lines, num_errors, tests_run} = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 7; i++) begin
			rd_reg((i == 6) ? 4'hf : 4'(i), d);
			check(16'(d), 16'h0000);
		end
		run <= 1'b1;
		for (i = 0; i < 10; i++) begin
			wr_reg(OFS_CONTROL, 8'h00);
			wr_reg(OFS_SOURCE, {6'h00, rows[i].src});
			wr_reg(OFS_CONTROL, {4'h8, rows[i].mode});
			wr_reg(OFS_IRQ, 8'h00);
			pulse(rows[i].drv, rows[i].n);
			repeat (8) @(posedge clk);
			check(16'(flag), 16'(rows[i].exp));
		end
		wr_reg(OFS_SOURCE, 8'h00);
		repeat (40) @(posedge clk);
		run <= 1'b0;
		pulse(4'h1, 1);
		run <= 1'b1;
		repeat (1100) @(posedge clk);
		run <= 1'b0;
		pulse(4'h1, 1);
		rd_reg(OFS_LOW, d);
		check(16'(d), 16'(ta[7:0]));
		rd_reg(OFS_HIGH, d);
		check(16'(d), 16'(ta[15:8]));
		dir <= 1'b1;
		wr_reg(OFS_OPTION, 8'h02);
		wr_reg(OFS_LOW, 8'h10);
		wr_reg(OFS_HIGH, 8'h00);
		for (i = 0; i < 6; i++) begin
			tclr <= 1'b1;
			if (cm[i] != M_CLR)
				wr_reg(OFS_CONTROL, 8'h00);
			wr_reg(OFS_CONTROL, {4'h8, cm[i]});
			tclr <= 1'b0;
			wr_reg(OFS_IRQ, 8'h00);
			seen = 1'b0;
			run <= 1'b1;
			for (k = 0; k < 200 && flag !== 1'b1; k++) begin
				@(posedge clk);
				#1 seen = seen | cmp;
			end
			run <= 1'b0;
			repeat (3) begin
				@(posedge clk);
				#1 seen = seen | cmp;
			end
			check(16'(flag), 16'h0001);
			check(16'(seen), 16'h0001);
			check(16'(cmp), 16'(cm[i] inside {M_TGL_CLR, M_TGL, M_SET}));
			check(16'(ta < 16'h0002), 16'(cm[i] inside {M_TGL_CLR, M_PULSE_CLR}));
			check(16'({po, poe}),
				16'({1'b0, !(cm[i] inside {M_TGL_CLR, M_TGL, M_SET})}));
		end
		// second timer selected, push pull, toggle with clear
		wr_reg(OFS_OPTION, 8'h01);
		wr_reg(OFS_CONTROL, 8'h00);
		wr_reg(OFS_LOW, 8'(tb2 + 16'h0008));
		wr_reg(OFS_HIGH, 8'((tb2 + 16'h0008) >> 8));
		wr_reg(OFS_CONTROL, {4'h8, M_TGL_CLR});
		wr_reg(OFS_IRQ, 8'h00);
		run <= 1'b1;
		for (k = 0; k < 200 && flag !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		run <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check(16'(tb2 < 16'h0002), 16'h0001);
		check(16'({flag, cmp, po, poe}), 16'h000f);
		// pin driven as output still captures its own level
		wr_reg(OFS_CONTROL, 8'h00);
		wr_reg(OFS_CONTROL, {4'h8, M_CAP_RISE});
		wr_reg(OFS_IRQ, 8'h00);
		pulse(4'h1, 1);
		check(16'(flag), 16'h0001);
		wr_reg(OFS_IRQ, 8'h03);
		sleep <= 1'b1;
		truns <= 1'b1;
		@(posedge clk);
		#1 check(16'(wake), 16'h0001);
		rd_reg(OFS_IRQ, d);
		check(16'(d), 16'h0003);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 check(16'({flag, cmp, wake}), 16'h0000);
		final_report;
	end
endmodule // tccu_top_tb
